// >>> verilog/seeb_consts.svh
// seeb_consts.svh: offsets, field positions, reset values and timing figures
// of the two-wire memory slave; included by every design file that needs them
`ifndef SEEB_CONSTS_SVH
`define SEEB_CONSTS_SVH

// core clock
`define SEEB_CLK_NS          40
`define SEEB_CLK_KHZ         25000

// internal program duration, per variant, in ms
`define SEEB_PROG_MS_STD     10
`define SEEB_PROG_MS_LV      15

// input glitch filter width, in ns
`define SEEB_FILT_NS_STD     100
`define SEEB_FILT_NS_FAST    50

// slave address byte layout
`define SEEB_TYPE_MSB        7
`define SEEB_TYPE_LSB        4
`define SEEB_SEL_MSB         3
`define SEEB_SEL_LSB         1
`define SEEB_RW_BIT          0

// storage organisation
`define SEEB_BYTE_BITS       8
`define SEEB_PAGE_BYTES      16
`define SEEB_PAGES           16
`define SEEB_BYTE_IDX_W      8
`define SEEB_PAGE_IDX_W      4

// bit counter value once a whole byte has passed
`define SEEB_BITS_DONE       4'h8

// idle level of both bus lines
`define SEEB_LINE_IDLE       1'b1

`endif

// >>> verilog/seeb_pkg.sv
// seeb_pkg: types shared by the two-wire memory slave files
// assumes seeb_consts.svh is on the include path
`include "seeb_consts.svh"

package seeb_pkg;

   typedef logic [`SEEB_BYTE_BITS-1:0]  seeb_byte_t;
   typedef logic [`SEEB_BYTE_IDX_W-1:0] seeb_addr_t;

   typedef enum logic [9:0] {
      SEEB_IDLE      = 10'b00_0000_0001,
      SEEB_DEV_ADDR  = 10'b00_0000_0010,
      SEEB_WORD_ADDR = 10'b00_0000_0100,
      SEEB_WR_DATA   = 10'b00_0000_1000,
      SEEB_ACK_OUT   = 10'b00_0001_0000,
      SEEB_RD_DATA   = 10'b00_0010_0000,
      SEEB_RD_ACK    = 10'b00_0100_0000,
      SEEB_WAIT_STOP = 10'b00_1000_0000,
      SEEB_PROG      = 10'b01_0000_0000,
      SEEB_COMMIT    = 10'b10_0000_0000
   } seeb_state_e;

endpackage : seeb_pkg

// >>> verilog/seeb_in_filter.sv
// seeb_in_filter: two-flop synchroniser plus glitch filter per input bit
// assumes inputs are asynchronous pins; output is a filtered level flop
`timescale 1ns/1ns
`default_nettype none

module seeb_in_filter #(
   parameter int unsigned W        = 1,
   parameter int unsigned FILT_CYC = 3
) (
   input  wire logic          core_clk,
   input  wire logic          rst,
   input  wire logic          clk_en,
   input  wire logic [W-1:0]  pin_in,
   output var  logic [W-1:0]  level_q
);

   localparam int unsigned CW = $clog2(FILT_CYC + 1);

   logic [W-1:0]  meta_q;
   logic [W-1:0]  sync_q;
   logic [W-1:0]  level_d;
   logic [CW-1:0] cnt_q [W];
   logic [CW-1:0] cnt_d [W];

   // a level change must persist for FILT_CYC cycles before it is taken
   always_comb
   begin
      level_d = level_q;
      for (int i = 0; i < W; i++)
      begin
         cnt_d[i] = '0;
         if (sync_q[i] != level_q[i])
         begin
            if (cnt_q[i] == CW'(FILT_CYC - 1))
               level_d[i] = sync_q[i];
            else
               cnt_d[i] = cnt_q[i] + CW'(1);
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         meta_q  <= '1;
         sync_q  <= '1;
         level_q <= '1;
         for (int i = 0; i < W; i++)
            cnt_q[i] <= '0;
      end
      else if (clk_en)
      begin
         meta_q  <= pin_in;
         sync_q  <= meta_q;
         level_q <= level_d;
         for (int i = 0; i < W; i++)
            cnt_q[i] <= cnt_d[i];
      end
   end

endmodule : seeb_in_filter

`default_nettype wire

// >>> verilog/seeb_mem.sv
// seeb_mem: byte array with a one-page load buffer committed in one go
// assumes the controller loads bytes of one page, then pulses commit
`timescale 1ns/1ns
`default_nettype none
`include "seeb_consts.svh"

module seeb_mem
   import seeb_pkg::*;
(
   input  wire logic                core_clk,
   input  wire logic                rst,
   input  wire logic                clk_en,
   input  wire logic                buf_we,
   input  wire seeb_pkg::seeb_addr_t buf_addr,
   input  wire seeb_pkg::seeb_byte_t buf_data,
   input  wire logic                commit,
   input  wire seeb_pkg::seeb_addr_t rd_addr,
   output var  seeb_pkg::seeb_byte_t rd_data
);

   localparam int unsigned PW = `SEEB_PAGE_IDX_W;

   // one block of pages x bytes, addressed byte-wise
   seeb_byte_t          mem_q  [`SEEB_PAGES*`SEEB_PAGE_BYTES]; // see RULE_09
   seeb_byte_t          page_q [`SEEB_PAGE_BYTES];
   logic [`SEEB_PAGE_BYTES-1:0] mask_q;
   logic [PW-1:0]       page_sel_q;

   // storage itself is not reset; only the buffer bookkeeping is
   always_ff @(posedge core_clk)
   begin
      if (clk_en)
      begin
         rd_data <= mem_q[rd_addr];
         if (buf_we)
            page_q[buf_addr[PW-1:0]] <= buf_data;
         if (commit)
            for (int i = 0; i < `SEEB_PAGE_BYTES; i++)
               if (mask_q[i])
                  mem_q[{page_sel_q, PW'(i)}] <= page_q[i]; // see RULE_08
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         mask_q     <= '0;
         page_sel_q <= '0;
      end
      else if (clk_en)
      begin
         if (commit)
            mask_q <= '0;
         else if (buf_we)
         begin
            mask_q[buf_addr[PW-1:0]] <= 1'b1;
            page_sel_q <= buf_addr[`SEEB_BYTE_IDX_W-1:PW];
         end
      end
   end

endmodule : seeb_mem

`default_nettype wire

// >>> verilog/seeb_slave.sv
// seeb_slave: two-wire bus slave front end of a 256-byte memory
// assumes a bus master drives the clock line; the data line is open drain
// with an external pull-up; address-select pins are static straps
//
// How it works
// RULE_01: program cycle ends 10 ms (15 low-volt)
// RULE_02: no acknowledge while programming
// RULE_03: data line released while programming
// RULE_04: start opens, stop closes every frame
// RULE_05: receiver acknowledges each received byte
// RULE_06: respond only to matching device-type field
// RULE_07: address bits must match the select pins
// RULE_08: a page is sixteen consecutive bytes
// RULE_09: one block, sixteen pages of sixteen bytes
// RULE_10: no block-select bits inside slave address
// RULE_11: whole bus storage kept within 16384 bits
// RULE_12: pulses shorter than filter width ignored; code passes pulses over 80 ns (40 ns fast): 3 (2) samples 40 ns apart
// RULE_13: last address bit: one read, zero write
// RULE_14: acknowledge every byte after write addressing
// RULE_15: after programming, resume start and address matching
`timescale 1ns/1ns
`default_nettype none
`include "seeb_consts.svh"

module seeb_slave
   import seeb_pkg::*;
#(
   parameter bit          LOW_VOLT  = 1'b0,
   parameter bit          FAST_MODE = 1'b0,
   // device-type code: value is arbitrary
   parameter logic [3:0]  DEV_TYPE  = 4'h6,
   parameter int unsigned PROG_CYCLES =
      (LOW_VOLT ? `SEEB_PROG_MS_LV : `SEEB_PROG_MS_STD) * `SEEB_CLK_KHZ
) (
   input  wire logic  core_clk,
   input  wire logic  rst,
   input  wire logic  clk_en,
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   input  wire logic  address_select_bit0,
   input  wire logic  address_select_bit1,
   input  wire logic  address_select_bit2,
   output var  logic  sda_out,
   output var  logic  sda_oe,
   output var  logic  program_busy,
   output var  logic  selected
);

   import seeb_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // input filtering

   localparam int unsigned FILT_NS =
      FAST_MODE ? `SEEB_FILT_NS_FAST : `SEEB_FILT_NS_STD;
   // least width rounds up to whole cycles
   localparam int unsigned FILT_CALC =
      (FILT_NS + `SEEB_CLK_NS - 1) / `SEEB_CLK_NS;
   localparam int unsigned FILT_CYC = (FILT_CALC < 1) ? 1 : FILT_CALC;

   logic [4:0] filt_q;
   logic       scl_f;
   logic       sda_f;
   logic [2:0] strap_f;

   seeb_in_filter #(
      .W        (5),
      .FILT_CYC (FILT_CYC)
   ) u_filter (
      .core_clk (core_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .pin_in   ({address_select_bit2, address_select_bit1,
                  address_select_bit0, scl_in, sda_in}), // see RULE_12
      .level_q  (filt_q)
   );

   assign sda_f   = filt_q[0];
   assign scl_f   = filt_q[1];
   assign strap_f = filt_q[4:2];

   ////////////////////////////////////////////////////////////////////////
   // bus events

   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;

   assign scl_rise = scl_f & ~scl_prev_q;
   assign scl_fall = ~scl_f & scl_prev_q;
   assign start_ev = scl_f & scl_prev_q & sda_prev_q & ~sda_f; // see RULE_04
   assign stop_ev  = scl_f & scl_prev_q & ~sda_prev_q & sda_f; // see RULE_04

   ////////////////////////////////////////////////////////////////////////
   // memory

   seeb_byte_t rd_data;
   logic       buf_we;
   logic       commit;
   seeb_addr_t addr_q;
   seeb_addr_t addr_d;
   seeb_byte_t shift_q;
   seeb_byte_t shift_d;

   seeb_mem u_mem (
      .core_clk (core_clk),
      .rst      (rst),
      .clk_en   (clk_en),
      .buf_we   (buf_we),
      .buf_addr (addr_q),
      .buf_data (shift_q),
      .commit   (commit),
      .rd_addr  (addr_q),
      .rd_data  (rd_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // protocol state

   seeb_state_e state_q;
   seeb_state_e state_d;
   seeb_state_e after_ack_q;
   seeb_state_e after_ack_d;
   logic [3:0]  bit_cnt_q;
   logic [3:0]  bit_cnt_d;
   logic        oe_q;
   logic        oe_d;
   logic        wrote_q;
   logic        wrote_d;
   logic        acked_q;
   logic        acked_d;
   logic        sel_q;
   logic        sel_d;
   logic [31:0] prog_cnt_q;
   logic [31:0] prog_cnt_d;
   logic        addr_match;
   logic        byte_done;

   // the whole memory is one block, so no address bit picks a block
   assign addr_match =
      (shift_q[`SEEB_TYPE_MSB:`SEEB_TYPE_LSB] == DEV_TYPE) &&   // see RULE_06
      (shift_q[`SEEB_SEL_MSB:`SEEB_SEL_LSB] == strap_f);        // see RULE_07
                                                                 // see RULE_10
   assign byte_done = scl_fall && (bit_cnt_q == `SEEB_BITS_DONE);

   // page write wraps inside the current page
   function automatic seeb_addr_t page_next(input seeb_addr_t a);
      page_next = {a[7:4], a[3:0] + 4'h1};
   endfunction : page_next

   always_comb
   begin
      state_d     = state_q;
      after_ack_d = after_ack_q;
      bit_cnt_d   = bit_cnt_q;
      shift_d     = shift_q;
      addr_d      = addr_q;
      oe_d        = oe_q;
      wrote_d     = wrote_q;
      acked_d     = acked_q;
      sel_d       = sel_q;
      prog_cnt_d  = prog_cnt_q;
      buf_we      = 1'b0;
      commit      = 1'b0;

      // receive shift for every incoming byte
      if (scl_rise && bit_cnt_q != `SEEB_BITS_DONE &&
          (state_q == SEEB_DEV_ADDR || state_q == SEEB_WORD_ADDR ||
           state_q == SEEB_WR_DATA))
      begin
         shift_d   = {shift_q[6:0], sda_f};
         bit_cnt_d = bit_cnt_q + 4'h1;
      end

      case (state_q)
         SEEB_IDLE, SEEB_WAIT_STOP:
            oe_d = 1'b0;
         SEEB_DEV_ADDR:
            if (byte_done)
            begin
               bit_cnt_d = '0;
               if (addr_match)
               begin
                  oe_d  = 1'b1;                              // see RULE_05
                  sel_d = 1'b1;
                  if (shift_q[`SEEB_RW_BIT])                 // see RULE_13
                     after_ack_d = SEEB_RD_DATA;
                  else
                     after_ack_d = SEEB_WORD_ADDR;
                  state_d = SEEB_ACK_OUT;
               end
               else
                  state_d = SEEB_WAIT_STOP;
            end
         SEEB_WORD_ADDR:
            if (byte_done)
            begin
               bit_cnt_d   = '0;
               addr_d      = shift_q;
               oe_d        = 1'b1;                           // see RULE_14
               after_ack_d = SEEB_WR_DATA;
               state_d     = SEEB_ACK_OUT;
            end
         SEEB_WR_DATA:
            if (byte_done)
            begin
               bit_cnt_d   = '0;
               buf_we      = 1'b1;                           // see RULE_08
               addr_d      = page_next(addr_q);
               wrote_d     = 1'b1;
               oe_d        = 1'b1;                           // see RULE_14
               after_ack_d = SEEB_WR_DATA;
               state_d     = SEEB_ACK_OUT;
            end
         SEEB_ACK_OUT:
            if (scl_fall)
            begin
               state_d = after_ack_q;
               oe_d    = 1'b0;
               if (after_ack_q == SEEB_RD_DATA)
               begin
                  // first data bit goes out on the same falling edge
                  shift_d   = rd_data;
                  addr_d    = addr_q + 8'h01;
                  oe_d      = ~rd_data[7];
                  bit_cnt_d = 4'h1;
               end
            end
         SEEB_RD_DATA:
            if (scl_fall)
            begin
               if (bit_cnt_q == `SEEB_BITS_DONE)
               begin
                  oe_d    = 1'b0;
                  state_d = SEEB_RD_ACK;
               end
               else
               begin
                  shift_d   = {shift_q[6:0], 1'b0};
                  oe_d      = ~shift_q[6];
                  bit_cnt_d = bit_cnt_q + 4'h1;
               end
            end
         SEEB_RD_ACK:
         begin
            // the master acknowledges what the device sent
            if (scl_rise)
               acked_d = ~sda_f;                             // see RULE_05
            if (scl_fall)
            begin
               if (acked_q)
               begin
                  // next byte leaves on the ack slot's own falling edge
                  addr_d      = addr_q + 8'h01;
                  state_d     = SEEB_RD_DATA;
                  shift_d     = rd_data;
                  oe_d        = ~rd_data[7];
                  bit_cnt_d   = 4'h1;
               end
               else
                  state_d = SEEB_WAIT_STOP;
            end
         end
         SEEB_PROG:
         begin
            oe_d = 1'b0;                                     // see RULE_03
            if (prog_cnt_q == 32'(PROG_CYCLES - 1))          // see RULE_01
               state_d = SEEB_COMMIT;
            else
               prog_cnt_d = prog_cnt_q + 32'h1;
         end
         SEEB_COMMIT:
         begin
            commit  = 1'b1;
            wrote_d = 1'b0;
            state_d = SEEB_IDLE;                             // see RULE_15
         end
         default:
         begin
            state_d = SEEB_IDLE;
            oe_d    = 1'b0;
         end
      endcase

      // frame boundaries override the byte logic, except while programming
      if (state_q != SEEB_PROG && state_q != SEEB_COMMIT)   // see RULE_02
      begin
         if (start_ev)
         begin
            state_d   = SEEB_DEV_ADDR;                       // see RULE_04
            bit_cnt_d = '0;
            oe_d      = 1'b0;
            sel_d     = 1'b0;
         end
         else if (stop_ev)
         begin
            oe_d  = 1'b0;
            sel_d = 1'b0;
            if (wrote_q || (state_q == SEEB_WR_DATA && buf_we))
            begin
               state_d    = SEEB_PROG;                       // see RULE_01
               prog_cnt_d = '0;
            end
            else
               state_d = SEEB_IDLE;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q      <= SEEB_IDLE;
         after_ack_q  <= SEEB_IDLE;
         bit_cnt_q    <= '0;
         shift_q      <= '0;
         addr_q       <= '0;
         oe_q         <= 1'b0;
         wrote_q      <= 1'b0;
         acked_q      <= 1'b0;
         sel_q        <= 1'b0;
         prog_cnt_q   <= '0;
         scl_prev_q   <= `SEEB_LINE_IDLE;
         sda_prev_q   <= `SEEB_LINE_IDLE;
         sda_oe       <= 1'b0;
         sda_out      <= 1'b0;
         program_busy <= 1'b0;
         selected     <= 1'b0;
      end
      else if (clk_en)
      begin
         state_q      <= state_d;
         after_ack_q  <= after_ack_d;
         bit_cnt_q    <= bit_cnt_d;
         shift_q      <= shift_d;
         addr_q       <= addr_d;
         oe_q         <= oe_d;
         wrote_q      <= wrote_d;
         acked_q      <= acked_d;
         sel_q        <= sel_d;
         prog_cnt_q   <= prog_cnt_d;
         scl_prev_q   <= scl_f;
         sda_prev_q   <= sda_f;
         // open drain: only ever pulls low
         sda_oe       <= oe_d;
         sda_out      <= 1'b0;
         program_busy <= (state_d == SEEB_PROG) || (state_d == SEEB_COMMIT);
         selected     <= sel_d;
      end
   end

endmodule : seeb_slave

`default_nettype wire

// >>> tb/seeb_slave_assertions.sv
// checker of the two-wire memory slave, watching its top ports only
// assumes the bench scales the program cycle through PROG_CYCLES
`timescale 1ns/1ns
`default_nettype none

module seeb_slave_assertions #(
   parameter int unsigned PROG_CYCLES = 250000
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic address_select_bit0,
   input wire logic address_select_bit1,
   input wire logic address_select_bit2,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic program_busy,
   input wire logic selected
);
   logic [31:0] busy_cnt_d;
   logic [31:0] busy_cnt_q;

   // counts enabled cycles of the program phase so far
   always_comb
   begin
      busy_cnt_d = busy_cnt_q;
      if (rst)
         busy_cnt_d = '0;
      else if (clk_en)
         busy_cnt_d = program_busy ? busy_cnt_q + 32'h1 : '0;
   end

   always_ff @(posedge core_clk)
   begin
      busy_cnt_q <= busy_cnt_d;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////
   a_never_high: assert property (sda_out == 1'b0)
      else $error("data pin driven high");
   a_busy_quiet: assert property (program_busy |-> !sda_oe)
      else $error("data line pulled during program cycle");
   a_busy_unsel: assert property (program_busy |-> !selected)
      else $error("selected during program cycle");
   a_busy_max: assert property (program_busy |-> busy_cnt_q <= PROG_CYCLES + 1)
      else $error("program cycle too long");
   a_busy_min: assert property ($fell(program_busy) && clk_en |-> busy_cnt_q >= PROG_CYCLES)
      else $error("program cycle too short");
   a_busy_on_stop: assert property ($rose(program_busy) |-> scl_in && sda_in)
      else $error("program cycle without stop");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 3))
      else $error("data drive changed outside clock low");
   a_stop_drops: assert property (selected && scl_in && $past(scl_in) && $rose(sda_in)
      |-> ##[1:10] !selected)
      else $error("stop did not end selection");
   a_start_drops: assert property (selected && scl_in && $past(scl_in) && $fell(sda_in)
      |-> ##[1:10] !selected)
      else $error("start did not end selection");
   a_en_freeze: assert property (!clk_en |=> $stable(sda_oe) && $stable(program_busy))
      else $error("state moved with clock enable low");

endmodule : seeb_slave_assertions

bind seeb_slave seeb_slave_assertions #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
   .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .scl_in(scl_in),
   .sda_in(sda_in), .address_select_bit0(address_select_bit0),
   .address_select_bit1(address_select_bit1),
   .address_select_bit2(address_select_bit2), .sda_out(sda_out),
   .sda_oe(sda_oe), .program_busy(program_busy), .selected(selected));

`default_nettype wire

// >>> tb/seeb_bus_master.sv
// behavioural two-wire bus master driving the clock and pulling data low
// assumes the bench resolves the data wire with a pull-up
`timescale 1ns/1ns
`default_nettype none

module seeb_bus_master (
   output var  logic scl,
   output var  logic sda_low,
   input  wire logic sda
);
   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   // clock low 360 ns so the slave's delayed drive settles before the rise
   task automatic slot(input logic b, output logic seen);
      #240 sda_low = ~b;
      #120 scl = 1'b1;
      seen = sda;
      #160 scl = 1'b0;
   endtask : slot

   task automatic start();
      if (scl == 1'b0)
      begin
         #240 sda_low = 1'b0;
         #120 scl = 1'b1;
         #160;
      end
      sda_low = 1'b1;
      #160 scl = 1'b0;
   endtask : start

   // bus stays free long enough for the program cycle to begin
   task automatic stop();
      #240 sda_low = 1'b1;
      #120 scl = 1'b1;
      #160 sda_low = 1'b0;
      #640;
   endtask : stop

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--)
         slot(b[i], seen);
      slot(1'b1, seen);
      ack = ~seen;
   endtask : send_byte

   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic seen;
      for (int i = 7; i >= 0; i--)
         slot(1'b1, b[i]);
      slot(last, seen);
   endtask : recv_byte

   // clock pulse shorter than the input filter, sent while the clock is low
   task automatic glitch();
      #240 scl = 1'b1;
      #80 scl = 1'b0;
      #200;
   endtask : glitch

endmodule : seeb_bus_master

`default_nettype wire

// >>> tb/seeb_slave_tb.sv
// self-checking bench of the two-wire memory slave, one device on the bus
// assumes seeb_consts.svh on the include path; program cycle scaled to 50
`timescale 1ns/1ns
`default_nettype none

module seeb_slave_tb;
   import seeb_pkg::*;
   localparam int unsigned PROG      = 50;
   // device-type code: value is arbitrary
   localparam logic [3:0]  TYPE_CODE = 4'h6;

   logic       core_clk = 1'b0;
   logic       rst;
   logic       clk_en;
   logic [2:0] strap;
   logic       scl;
   logic       m_low;
   logic       sda_wire;
   logic       sda_out;
   logic       sda_oe;
   logic       program_busy;
   logic       selected;
   // one device of one block on the bus stays far inside the bus limit
   seeb_byte_t exp_mem [256];
   int         miscompares = 0;
   int         n_checks = 0;
   integer     seed = 32'haaffdf9b;

   always #20 core_clk = ~core_clk;
   assign sda_wire = (sda_oe === 1'b1 ? sda_out : 1'b1) & ~m_low;

   seeb_slave #(.DEV_TYPE(TYPE_CODE), .PROG_CYCLES(PROG)) i_dut (
      .core_clk(core_clk), .rst(rst), .clk_en(clk_en), .scl_in(scl),
      .sda_in(sda_wire), .address_select_bit0(strap[0]),
      .address_select_bit1(strap[1]), .address_select_bit2(strap[2]),
      .sda_out(sda_out), .sda_oe(sda_oe), .program_busy(program_busy),
      .selected(selected));

   seeb_bus_master i_master (.scl(scl), .sda_low(m_low), .sda(sda_wire));

   ////////////////////////////////////////////////////////////////////////////
   function automatic seeb_byte_t addr_byte(input logic [3:0] t,
                                            input logic [2:0] s,
                                            input logic       rd);
      return {t, s, rd};
   endfunction : addr_byte

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      #2000000;
      miscompares++;
      report_and_stop();
   end

   initial
   begin
      logic       a;
      logic [3:0] t;
      logic [2:0] s;
      logic [7:0] b;
      logic [7:0] wa;
      rst = 1'b1;
      clk_en = 1'b1;
      strap = $random(seed);
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      repeat (10) @(negedge core_clk);
      clk_en = 1'b0;
      repeat (3) @(negedge core_clk);
      clk_en = 1'b1;
      // a short clock pulse inside a frame must not shift an extra bit
      i_master.start();
      i_master.glitch();
      i_master.send_byte(addr_byte(TYPE_CODE, strap, 1'b0), a);
      chk("ack after glitch", 8'h1, a);
      i_master.stop();
      for (int k = 0; k < 6; k++)
      begin
         t = (k % 2) ? TYPE_CODE : TYPE_CODE ^ (4'h1 << (k / 2));
         s = (k % 2) ? strap ^ (3'h1 << (k / 2)) : strap;
         i_master.start();
         i_master.send_byte(addr_byte(t, s, 1'b0), a);
         chk("foreign address ack", 8'h0, a);
         i_master.stop();
      end
      for (int r = 0; r < 2; r++)
      begin
         wa = $random(seed);
         i_master.start();
         i_master.send_byte(addr_byte(TYPE_CODE, strap, 1'b0), a);
         chk("write address ack", 8'h1, a);
         chk("selected after ack", 8'h1, selected);
         i_master.send_byte(wa, a);
         chk("word address ack", 8'h1, a);
         // seventeen bytes: the last one overwrites the first
         for (int k = 0; k < 17; k++)
         begin
            b = $random(seed);
            exp_mem[{wa[7:4], wa[3:0] + k[3:0]}] = b;
            i_master.send_byte(b, a);
            chk("data ack", 8'h1, a);
         end
         i_master.stop();
         chk("busy after stop", 8'h1, program_busy);
         chk("selected after stop", 8'h0, selected);
         i_master.start();
         i_master.send_byte(addr_byte(TYPE_CODE, strap, 1'b0), a);
         chk("ack while busy", 8'h0, a);
         i_master.stop();
         chk("busy ended", 8'h0, program_busy);
         i_master.start();
         i_master.send_byte(addr_byte(TYPE_CODE, strap, 1'b0), a);
         chk("ack after program", 8'h1, a);
         i_master.send_byte({wa[7:4], 4'h0}, a);
         i_master.start();
         i_master.send_byte(addr_byte(TYPE_CODE, strap, 1'b1), a);
         chk("read address ack", 8'h1, a);
         for (int k = 0; k < 16; k++)
         begin
            i_master.recv_byte(k == 15, b);
            chk("read data", exp_mem[{wa[7:4], k[3:0]}], b);
         end
         i_master.stop();
      end
      report_and_stop();
   end

endmodule : seeb_slave_tb

`default_nettype wire
